// [pkg/afx_pkg.sv]
// Constants shared by the FIFO pin controller and its output buffer
`default_nettype none
package afx_pkg;
  localparam int DATA_W         = 9;
  localparam int CLK_MHZ        = 25;
  localparam int SYNC_STAGES    = 2;
  // Times in ns
  localparam int T_STROBE_NS    = 80;
  localparam int T_HIGH_NS      = 80;
  localparam int T_RESET_NS     = 100;
  localparam int T_RESET_REC_NS = 100;
  // Cycle counts, least times rounded up
  localparam int STROBE_CYC     = (T_STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int HIGH_CYC       = (T_HIGH_NS * CLK_MHZ + 999) / 1000;
  localparam int RESET_CYC      = (T_RESET_NS * CLK_MHZ + 999) / 1000;
  localparam int RESET_REC_CYC  = (T_RESET_REC_NS * CLK_MHZ + 999) / 1000
                                  + SYNC_STAGES;
  // Read low covers access time plus the data synchroniser
  localparam int READ_LOW_CYC   = STROBE_CYC + SYNC_STAGES;
  // Flags need their settle time plus the synchroniser
  localparam int SETTLE_CYC     = HIGH_CYC + SYNC_STAGES;
  localparam int CNT_W          = 4;
  // Reset values of the pin drivers
  localparam logic RST_STROBE_N = 1'b1;
  localparam logic RST_DEV_RST_N = 1'b0;
  localparam logic RST_RETX_N   = 1'b1;
  localparam logic [1:0] BUF_DEPTH = 2'h2;

  typedef enum logic [5:0] {
    ST_RST  = 6'h01,
    ST_REC  = 6'h02,
    ST_IDLE = 6'h04,
    ST_WR   = 6'h08,
    ST_RD   = 6'h10,
    ST_RTX  = 6'h20
  } afx_state_e;
endpackage : afx_pkg
`default_nettype wire

// [rtl/afx_buf2.sv]
// Two-entry buffer with valid/ready on both sides
`default_nettype none
module afx_buf2
  import afx_pkg::*;
#(
  parameter int W = DATA_W
)(
  input  wire logic         clk_sys_in,
  input  wire logic         rst_n_in,
  input  wire logic         in_valid_in,
  input  wire logic [W-1:0] in_data_in,
  output logic              in_ready_out,
  output logic              out_valid_out,
  output logic [W-1:0]      out_data_out,
  input  wire logic         out_ready_in
);
  logic [W-1:0] slot0_reg;
  logic [W-1:0] slot0_next;
  logic [W-1:0] slot1_reg;
  logic [W-1:0] slot1_next;
  logic [1:0]   count_reg;
  logic [1:0]   count_next;
  logic         push;
  logic         pop;

  assign in_ready_out  = (count_reg != BUF_DEPTH);
  assign out_valid_out = (count_reg != 2'h0);
  assign out_data_out  = slot0_reg;
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;

  always_comb
  begin
    slot0_next = slot0_reg;
    slot1_next = slot1_reg;
    count_next = count_reg;
    if (pop)
    begin
      slot0_next = slot1_reg;
    end
    if (push)
    begin
      if (count_reg == 2'h0 || (count_reg == 2'h1 && pop))
        slot0_next = in_data_in;
      else if (pop)
        slot1_next = in_data_in;
      else
        slot1_next = in_data_in;
    end
    if (push && !pop)
      count_next = count_reg + 2'h1;
    else if (pop && !push)
      count_next = count_reg - 2'h1;
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      slot0_reg <= '0;
      slot1_reg <= '0;
      count_reg <= 2'h0;
    end
    else
    begin
      slot0_reg <= slot0_next;
      slot1_reg <= slot1_next;
      count_reg <= count_next;
    end
  end
endmodule : afx_buf2
`default_nettype wire

// [rtl/afx_host.sv]
// Controller that drives an asynchronous FIFO through its pins
`default_nettype none
module afx_host
  import afx_pkg::*;
#(
  parameter int NUM_DEV = 1
)(
  input  wire logic               clk_sys_in,
  input  wire logic               rst_n_in,
  input  wire logic               depth_mode_in,
  input  wire logic               wr_valid_in,
  input  wire logic [DATA_W-1:0]  wr_data_in,
  output logic                    wr_ready_out,
  input  wire logic               rd_enable_in,
  output logic                    rd_valid_out,
  output logic [DATA_W-1:0]       rd_data_out,
  input  wire logic               rd_ready_in,
  input  wire logic               reset_req_in,
  input  wire logic               retx_req_in,
  output logic                    busy_out,
  output logic                    full_out,
  output logic                    empty_out,
  output logic                    half_full_out,
  output logic                    write_n_out,
  output logic                    read_n_out,
  output logic                    reset_n_out,
  output logic [DATA_W-1:0]       data_in_out,
  output logic [NUM_DEV-1:0]      load_retx_n_out,
  output logic                    expansion_in_n_out,
  output logic                    expansion_in_oe_n_out,
  input  wire logic [DATA_W-1:0]  data_out_in,
  input  wire logic [NUM_DEV-1:0] full_flag_n_in,
  input  wire logic [NUM_DEV-1:0] empty_flag_n_in,
  input  wire logic               half_full_n_in
);
  logic [NUM_DEV-1:0] full_s1_reg;
  logic [NUM_DEV-1:0] full_s2_reg;
  logic [NUM_DEV-1:0] empty_s1_reg;
  logic [NUM_DEV-1:0] empty_s2_reg;
  logic               hf_s1_reg;
  logic               hf_s2_reg;
  logic [DATA_W-1:0]  dout_s1_reg;
  logic [DATA_W-1:0]  dout_s2_reg;

  afx_state_e         state_reg;
  afx_state_e         state_next;
  logic [CNT_W-1:0]   cnt_reg;
  logic [CNT_W-1:0]   cnt_next;
  logic               pref_rd_reg;
  logic               pref_rd_next;
  logic [DATA_W-1:0]  wdata_reg;
  logic [DATA_W-1:0]  wdata_next;
  logic               write_n_reg;
  logic               write_n_next;
  logic               read_n_reg;
  logic               read_n_next;
  logic               dev_rst_n_reg;
  logic               dev_rst_n_next;
  logic               retx_n_reg;
  logic               retx_n_next;

  logic               full_ok;
  logic               data_ok;
  logic               rd_possible;
  logic               start_wr;
  logic               start_rd;
  logic               buf_in_valid;
  logic               buf_in_ready;

  // Pins come from the device's own timing, so two stages each
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      full_s1_reg  <= '0;
      full_s2_reg  <= '0;
      empty_s1_reg <= '0;
      empty_s2_reg <= '0;
      hf_s1_reg    <= 1'b1;
      hf_s2_reg    <= 1'b1;
      dout_s1_reg  <= '0;
      dout_s2_reg  <= '0;
    end
    else
    begin
      full_s1_reg  <= full_flag_n_in;
      full_s2_reg  <= full_s1_reg;
      empty_s1_reg <= empty_flag_n_in;
      empty_s2_reg <= empty_s1_reg;
      hf_s1_reg    <= half_full_n_in;
      hf_s2_reg    <= hf_s1_reg;
      dout_s1_reg  <= data_out_in;
      dout_s2_reg  <= dout_s1_reg;
    end
  end

  assign full_ok = depth_mode_in ? (|full_s2_reg) : full_s2_reg[0];
  assign data_ok = depth_mode_in ? (|empty_s2_reg) : empty_s2_reg[0];

  assign rd_possible = rd_enable_in && data_ok && buf_in_ready;
  assign start_wr = wr_valid_in && full_ok && !(rd_possible && pref_rd_reg)
                    && !reset_req_in && !retx_req_in;
  assign start_rd = rd_possible && !start_wr && !reset_req_in
                    && !retx_req_in;
  assign wr_ready_out = (state_reg == ST_IDLE) && start_wr;

  always_comb
  begin
    state_next   = state_reg;
    cnt_next     = (cnt_reg != '0) ? cnt_reg - 1'b1 : cnt_reg;
    pref_rd_next = pref_rd_reg;
    wdata_next   = wdata_reg;
    case (state_reg)
      ST_RST:
        if (cnt_reg == '0)
        begin
          state_next = ST_REC;
          cnt_next   = CNT_W'(RESET_REC_CYC - 1);
        end
      ST_REC:
        if (cnt_reg == '0)
          state_next = ST_IDLE;
      ST_IDLE:
        if (reset_req_in)
        begin
          state_next = ST_RST;
          cnt_next   = CNT_W'(RESET_CYC - 1);
        end
        else if (retx_req_in && !depth_mode_in)
        begin
          state_next = ST_RTX;
          cnt_next   = CNT_W'(STROBE_CYC - 1);
        end
        else if (start_wr)
        begin
          state_next   = ST_WR;
          cnt_next     = CNT_W'(STROBE_CYC - 1);
          wdata_next   = wr_data_in;
          pref_rd_next = 1'b1;
        end
        else if (start_rd)
        begin
          state_next   = ST_RD;
          cnt_next     = CNT_W'(READ_LOW_CYC - 1);
          pref_rd_next = 1'b0;
        end
      ST_WR, ST_RD, ST_RTX:
        // Wait out flag settle before the next decision
        if (cnt_reg == '0)
        begin
          state_next = ST_REC;
          cnt_next   = CNT_W'(SETTLE_CYC - 1);
        end
      default:
      begin
        state_next = ST_RST;
        cnt_next   = CNT_W'(RESET_CYC - 1);
      end
    endcase
    write_n_next   = (state_next != ST_WR);
    read_n_next    = (state_next != ST_RD);
    dev_rst_n_next = (state_next != ST_RST);
    retx_n_next    = (state_next != ST_RTX);
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_reg     <= ST_RST;
      cnt_reg       <= CNT_W'(RESET_CYC - 1);
      pref_rd_reg   <= 1'b0;
      wdata_reg     <= '0;
      write_n_reg   <= RST_STROBE_N;
      read_n_reg    <= RST_STROBE_N;
      dev_rst_n_reg <= RST_DEV_RST_N;
      retx_n_reg    <= RST_RETX_N;
    end
    else
    begin
      state_reg     <= state_next;
      cnt_reg       <= cnt_next;
      pref_rd_reg   <= pref_rd_next;
      wdata_reg     <= wdata_next;
      write_n_reg   <= write_n_next;
      read_n_reg    <= read_n_next;
      dev_rst_n_reg <= dev_rst_n_next;
      retx_n_reg    <= retx_n_next;
    end
  end

  assign write_n_out = write_n_reg;
  assign read_n_out  = read_n_reg;
  assign reset_n_out = dev_rst_n_reg;
  assign data_in_out = wdata_reg;
  assign busy_out    = (state_reg != ST_IDLE);
  assign full_out    = !full_ok;
  assign empty_out   = !data_ok;
  assign half_full_out = !depth_mode_in && !hf_s2_reg;

  assign expansion_in_n_out    = 1'b0;
  assign expansion_in_oe_n_out = depth_mode_in;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_DEV; gi++)
    begin : g_load
      assign load_retx_n_out[gi] = depth_mode_in ? (gi != 0) : retx_n_reg;
    end
  endgenerate

  // Last read-low cycle: synchronised data already settled
  assign buf_in_valid = (state_reg == ST_RD) && (cnt_reg == '0);

  afx_buf2 #(
    .W (DATA_W)
  ) u_buf (
    .clk_sys_in    (clk_sys_in),
    .rst_n_in      (rst_n_in),
    .in_valid_in   (buf_in_valid),
    .in_data_in    (dout_s2_reg),
    .in_ready_out  (buf_in_ready),
    .out_valid_out (rd_valid_out),
    .out_data_out  (rd_data_out),
    .out_ready_in  (rd_ready_in)
  );

  property p_wr_when_room;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      $fell(write_n_out) |-> $past(full_ok);
  endproperty
  a_wr_when_room: assert property (p_wr_when_room)
    else $error("write strobe while full");

  property p_rd_when_data;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      $fell(read_n_out) |-> $past(data_ok) && $past(buf_in_ready);
  endproperty
  a_rd_when_data: assert property (p_rd_when_data)
    else $error("read strobe while empty or buffer full");

  property p_retx_quiet;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      !retx_n_reg |-> write_n_out && read_n_out && !depth_mode_in;
  endproperty
  a_retx_quiet: assert property (p_retx_quiet)
    else $error("strobe low during retransmit");

  property p_reset_quiet;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      $rose(reset_n_out) |-> (write_n_out && read_n_out) [*5];
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("strobe moved near reset release");

  property p_reset_width;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      $fell(reset_n_out) |-> !reset_n_out [*3];
  endproperty
  a_reset_width: assert property (p_reset_width)
    else $error("device reset too short");

  property p_single_tie;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      !depth_mode_in |-> !expansion_in_oe_n_out && !expansion_in_n_out;
  endproperty
  a_single_tie: assert property (p_single_tie)
    else $error("expansion input not tied low");

  property p_chain_release;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      depth_mode_in |-> expansion_in_oe_n_out;
  endproperty
  a_chain_release: assert property (p_chain_release)
    else $error("expansion input driven in chain");

  property p_first_load;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      depth_mode_in |-> $countones(~load_retx_n_out) == 1
                        && !load_retx_n_out[0];
  endproperty
  a_first_load: assert property (p_first_load)
    else $error("first-load not unique");

  property p_common_ctl;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      !depth_mode_in |-> (&load_retx_n_out) || !(|load_retx_n_out);
  endproperty
  a_common_ctl: assert property (p_common_ctl)
    else $error("width controls differ");

  property p_strobe_width;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      $fell(write_n_out) |-> !write_n_out [*2] ##1 write_n_out [*4];
  endproperty
  a_strobe_width: assert property (p_strobe_width)
    else $error("write strobe timing wrong");

  // Composite is empty only when every device reports empty
  property p_composite;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      depth_mode_in && (|empty_s2_reg) |-> !empty_out;
  endproperty
  a_composite: assert property (p_composite)
    else $error("composite empty wrong");
endmodule : afx_host
`default_nettype wire

// [test/afx_fifo_model.sv]
// Behavioural model of the asynchronous FIFO device at the pins
`default_nettype none
module afx_fifo_model
  import afx_pkg::*;
#(
  parameter int DEPTH = 8
)(
  input  wire logic              write_n_in,
  input  wire logic              read_n_in,
  input  wire logic              reset_n_in,
  input  wire logic              retx_n_in,
  input  wire logic              exp_in_n_in,
  input  wire logic [DATA_W-1:0] data_in_in,
  output logic [DATA_W-1:0]      data_out_out,
  output logic                   full_flag_n_out,
  output logic                   empty_flag_n_out,
  output logic                   half_full_n_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [DATA_W-1:0] mem_reg [DEPTH];
  logic [DATA_W-1:0] q_reg = 9'h000;
  int               wp = 0;
  int               rp = 0;
  int               cnt = 0;
  logic             wr_go = 1'b0;
  logic             rd_go = 1'b0;
  logic             hf_reg = 1'b1;
  logic             wr_tok = 1'b0;
  logic             rd_tok = 1'b0;
  logic             xo_n   = 1'b1;
  always @(negedge reset_n_in)
  begin
    wp = 0; rp = 0; cnt = 0; hf_reg = 1'b1; wr_go = 1'b0; rd_go = 1'b0;
    // first-load low starts with both tokens
    wr_tok = !retx_n_in;
    rd_tok = !retx_n_in;
  end
  // token arrives as a low pulse
  always @(negedge exp_in_n_in)
    if (reset_n_in)
    begin
      wr_tok = 1'b1;
      rd_tok = 1'b1;
    end
  // chain-out pulse has a fixed width
  always @(negedge xo_n)
    #40 xo_n = 1'b1;
  // retransmit moves read pointer, single mode only
  always @(negedge retx_n_in)
    if (reset_n_in && !exp_in_n_in)
    begin
      rp = 0; cnt = wp;
    end
  // write starts only when not full
  always @(negedge write_n_in)
    if (reset_n_in)
    begin
      wr_go = (cnt < DEPTH) && (!exp_in_n_in || wr_tok);
      if (wr_go && cnt >= DEPTH / 2) hf_reg = 1'b0;
    end
  always @(posedge write_n_in)
    if (wr_go)
    begin
      mem_reg[wp] = data_in_in; wp = (wp + 1) % DEPTH; cnt++; wr_go = 1'b0;
      // last location passes the write token on
      if (exp_in_n_in && wp == 0)
      begin
        wr_tok = 1'b0;
        xo_n = 1'b0;
      end
      // read held low on empty: flag pulses, word flows out
      if (!read_n_in && !rd_go && cnt == 1 && (!exp_in_n_in || rd_tok))
      begin
        #10;
        q_reg = mem_reg[rp];
        rp = (rp + 1) % DEPTH;
        cnt--;
        rd_go = 1'b1;
      end
    end
  // read starts only when not empty
  always @(negedge read_n_in)
    if (reset_n_in && cnt > 0 && (!exp_in_n_in || rd_tok))
    begin
      q_reg = mem_reg[rp]; rp = (rp + 1) % DEPTH; cnt--; rd_go = 1'b1;
      // last location passes the read token on
      if (exp_in_n_in && rp == 0)
      begin
        rd_tok = 1'b0;
        xo_n = 1'b0;
      end
    end
  always @(posedge read_n_in)
  begin
    if (rd_go && cnt <= DEPTH / 2) hf_reg = 1'b1;
    rd_go = 1'b0;
  end
  // floating bus shown as inverse, never the stale word
  assign data_out_out = (!read_n_in && rd_go) ? q_reg : ~q_reg;
  assign full_flag_n_out = (cnt != DEPTH);
  assign empty_flag_n_out = (cnt != 0);
  // half-full only in single mode, chain-out otherwise
  assign half_full_n_out = exp_in_n_in ? xo_n : hf_reg;
endmodule : afx_fifo_model
`default_nettype wire

// [test/tb_async_fifo_flags_expansion.sv]
// Self-checking bench for the FIFO pin controller
`default_nettype none
module tb_async_fifo_flags_expansion
  import afx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DEPTH = 8;
  localparam int LIMIT = 20000;
  logic clk_sys_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic depth_mode_in = 1'b0;
  logic wr_valid_in = 1'b0;
  logic [DATA_W-1:0] wr_data_in = 9'h000;
  logic rd_enable_in = 1'b0;
  logic rd_ready_in = 1'b0;
  logic reset_req_in = 1'b0;
  logic retx_req_in = 1'b0;
  logic wr_ready_out, rd_valid_out, busy_out, full_out, empty_out;
  logic half_full_out, write_n_out, read_n_out, reset_n_out;
  logic [DATA_W-1:0] rd_data_out, data_in_out, data_out_in;
  logic [0:0] load_retx_n_out, full_flag_n_in, empty_flag_n_in;
  logic expansion_in_n_out, expansion_in_oe_n_out, half_full_n_in;
  wire exp_wire = expansion_in_oe_n_out ? 1'b1 : expansion_in_n_out;
  int mismatches = 0;
  int checks = 0;
  int cyc = 0;
  int seen;

  always #20 clk_sys_in = ~clk_sys_in;

  afx_host #(.NUM_DEV(1)) dut_u (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .depth_mode_in(depth_mode_in), .wr_valid_in(wr_valid_in),
    .wr_data_in(wr_data_in), .wr_ready_out(wr_ready_out),
    .rd_enable_in(rd_enable_in), .rd_valid_out(rd_valid_out),
    .rd_data_out(rd_data_out), .rd_ready_in(rd_ready_in),
    .reset_req_in(reset_req_in), .retx_req_in(retx_req_in),
    .busy_out(busy_out), .full_out(full_out), .empty_out(empty_out),
    .half_full_out(half_full_out), .write_n_out(write_n_out),
    .read_n_out(read_n_out), .reset_n_out(reset_n_out),
    .data_in_out(data_in_out), .load_retx_n_out(load_retx_n_out),
    .expansion_in_n_out(expansion_in_n_out),
    .expansion_in_oe_n_out(expansion_in_oe_n_out),
    .data_out_in(data_out_in), .full_flag_n_in(full_flag_n_in),
    .empty_flag_n_in(empty_flag_n_in), .half_full_n_in(half_full_n_in));

  afx_fifo_model #(.DEPTH(DEPTH)) dev_u (
    .write_n_in(write_n_out), .read_n_in(read_n_out),
    .reset_n_in(reset_n_out), .retx_n_in(load_retx_n_out[0]),
    .exp_in_n_in(exp_wire), .data_in_in(data_in_out),
    .data_out_out(data_out_in), .full_flag_n_out(full_flag_n_in[0]),
    .empty_flag_n_out(empty_flag_n_in[0]),
    .half_full_n_out(half_full_n_in));

  task automatic print_verdict;
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : print_verdict

  task automatic cmp_word(input logic [DATA_W-1:0] got,
                          input logic [DATA_W-1:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_word

  task automatic cmp_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_bit

  function automatic logic [DATA_W-1:0] expw(input int i);
    return 9'h155 ^ DATA_W'(i * 9'h023);
  endfunction : expw

  // Idle plus a few cycles so synced flags are current
  task automatic wait_idle;
    do @(negedge clk_sys_in); while (busy_out !== 1'b0);
    repeat (4) @(negedge clk_sys_in);
  endtask : wait_idle

  task automatic push(input logic [DATA_W-1:0] w);
    @(posedge clk_sys_in);
    wr_valid_in <= 1'b1;
    wr_data_in <= w;
    do @(negedge clk_sys_in); while (wr_ready_out !== 1'b1);
    @(posedge clk_sys_in);
    wr_valid_in <= 1'b0;
  endtask : push

  task automatic pop(input logic [DATA_W-1:0] w);
    @(posedge clk_sys_in);
    rd_ready_in <= 1'b1;
    do @(negedge clk_sys_in); while (rd_valid_out !== 1'b1);
    cmp_word(rd_data_out, w);
    @(posedge clk_sys_in);
    rd_ready_in <= 1'b0;
  endtask : pop

  // One device command: reset or retransmit
  task automatic dev_cmd(input logic rtx);
    @(posedge clk_sys_in);
    if (rtx) retx_req_in <= 1'b1;
    else reset_req_in <= 1'b1;
    do @(negedge clk_sys_in); while (busy_out !== 1'b1);
    @(posedge clk_sys_in);
    retx_req_in <= 1'b0;
    reset_req_in <= 1'b0;
    wait_idle();
  endtask : dev_cmd

  always @(posedge clk_sys_in)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      mismatches++;
      print_verdict();
    end
  end

  initial
  begin
    repeat (20) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    wait_idle();
    cmp_bit(empty_out, 1'b1); // empty after reset
    cmp_bit(full_out, 1'b0); // not full
    cmp_bit(half_full_out, 1'b0); // half-full clear
    cmp_bit(reset_n_out, 1'b1); // reset released
    cmp_bit(exp_wire, 1'b0); // single mode
    for (int i = 0; i < DEPTH; i++)
    begin
      push(expw(i));
      wait_idle();
      cmp_bit(half_full_out, logic'(i >= DEPTH / 2)); // half-full
      cmp_bit(full_out, logic'(i == DEPTH - 1)); // full count
    end
    // Full device: request must be held off
    seen = 0;
    @(posedge clk_sys_in);
    wr_valid_in <= 1'b1;
    repeat (40)
    begin
      @(negedge clk_sys_in);
      if (wr_ready_out !== 1'b0 || write_n_out !== 1'b1) seen++;
    end
    cmp_bit(logic'(seen != 0), 1'b0); // no write while full
    @(posedge clk_sys_in);
    wr_valid_in <= 1'b0;
    // Reader stalls first, so buffer must hold words without loss
    rd_enable_in <= 1'b1;
    repeat (60) @(posedge clk_sys_in);
    cmp_bit(rd_valid_out, 1'b1); // reads while data present
    for (int i = 0; i < DEPTH; i++)
      pop(expw(i)); // order kept
    wait_idle();
    cmp_bit(empty_out, 1'b1); // empty after drain
    cmp_bit(full_out, 1'b0); // full released
    cmp_bit(half_full_out, 1'b0); // half-full released
    @(posedge clk_sys_in);
    rd_enable_in <= 1'b0;
    dev_cmd(1'b0);
    cmp_bit(empty_out, 1'b1); // reset empties
    for (int i = 0; i < 3; i++)
      push(expw(i + 8));
    rd_enable_in <= 1'b1;
    for (int i = 0; i < 3; i++)
      pop(expw(i + 8)); // words after reset
    rd_enable_in <= 1'b0;
    wait_idle();
    dev_cmd(1'b1);
    cmp_bit(empty_out, 1'b0); // retransmit rewinds read
    @(posedge clk_sys_in);
    rd_enable_in <= 1'b1;
    for (int i = 0; i < 3; i++)
      pop(expw(i + 8)); // same words again
    wait_idle();
    cmp_bit(empty_out, 1'b1); // empty again
    @(posedge clk_sys_in);
    rd_enable_in <= 1'b0;
    depth_mode_in <= 1'b1;
    repeat (8) @(negedge clk_sys_in);
    cmp_bit(half_full_out, 1'b0); // no half-full in chain
    cmp_bit(load_retx_n_out[0], 1'b0); // first device marked
    cmp_bit(expansion_in_oe_n_out, 1'b1); // chain input released
    // Chain mode needs a fresh reset so the first device holds the token
    dev_cmd(1'b0);
    cmp_bit(empty_out, 1'b1); // chain reset empties
    push(expw(11));
    wait_idle();
    cmp_bit(empty_out, 1'b0); // first device took word
    cmp_bit(full_out, 1'b0); // composite not full
    @(posedge clk_sys_in);
    rd_enable_in <= 1'b1;
    pop(expw(11)); // token device reads back
    print_verdict();
  end
endmodule : tb_async_fifo_flags_expansion
`default_nettype wire
